// ===== rtl/tcr_top.sv
// Transmit control, error insertion and reset control register bank.
`timescale 1ns/1ps
`default_nettype none
module tcr_top
	import tcr_pkg::*;
#(
	parameter int FRAME_CYCLES = TCR_FRAME_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       reg_select,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic     [7:0] reg_rdata,
	output logic            reg_rvalid,
	input  wire logic       d4_mode,
	input  wire logic       esf_mode,
	input  wire logic       tx_channel_valid,
	input  wire logic [7:0] tx_channel_data,
	input  wire logic       tx_channel_msg_sel,
	output logic            tx_channel_out_valid,
	output logic     [7:0] tx_channel_out,
	output logic     [7:0] tx_delay_setting,
	output logic            tx_delay_load,
	output logic            tx_frame_start,
	output logic            bipolar_violation_inject,
	output logic            crc6_fault_inject,
	output logic            terminal_framing_fault_inject,
	output logic            signalling_framing_fault_inject,
	output logic            payload_fault_inject,
	output logic            all_zeros_inject,
	input  wire logic       line_loss_status,
	input  wire logic       frame_loss_status,
	output logic            loss_indicator_pin,
	input  wire logic       irq_pending,
	output logic            irq_n_out,
	output logic            irq_n_oe,
	output logic            interrupt_ignore,
	output logic            interrupt_status_clear,
	output logic            counter_clear,
	input  wire logic       one_second_tick,
	output logic            counter_update_enable,
	output logic            soft_reset_pulse,
	output logic            ext_osc_select
);
	// ==========================================================
	// Reset release
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ==========================================================
	// Register decode
	logic       wr_hit;
	logic       wr_delay;
	logic       wr_message;
	logic       wr_errinj;
	logic       wr_resetctl;
	logic [7:0] delay_r;
	logic [7:0] message_r;
	logic [7:0] errinj_r;
	logic [7:0] resetctl_r;
	logic       soft_rst_r;
	logic       ack_r;
	logic [7:0] errinj_nxt;
	logic [7:0] pulses;

	assign wr_hit      = reg_select && reg_write;
	assign wr_delay    = wr_hit && (reg_addr == TCR_OFS_DELAY);
	assign wr_message  = wr_hit && (reg_addr == TCR_OFS_MESSAGE);
	assign wr_errinj   = wr_hit && (reg_addr == TCR_OFS_ERR_INJECT);
	assign wr_resetctl = wr_hit && (reg_addr == TCR_OFS_RESET_CTL);
	assign errinj_nxt  = reg_wdata & TCR_EI_WMASK;

	// A soft reset returns every control register to its default but is
	// not seen by the reset synchroniser, so the bus stays usable at once.
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			delay_r <= TCR_RST_DELAY;
		end else if (soft_rst_r) begin
			delay_r <= TCR_RST_DELAY;
		end else if (wr_delay) begin
			delay_r <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			message_r <= TCR_RST_MESSAGE;
		end else if (soft_rst_r) begin
			message_r <= TCR_RST_MESSAGE;
		end else if (wr_message) begin
			message_r <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			errinj_r <= TCR_RST_ERRINJ;
		end else if (soft_rst_r) begin
			errinj_r <= TCR_RST_ERRINJ;
		end else if (wr_errinj) begin
			errinj_r <= errinj_nxt;
		end
	end

	// Bits 7 and 5 never store: they are one-cycle actions that read back
	// as zero once done. The host is expected to keep bits 1:0 at zero.
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			resetctl_r <= TCR_RST_RESET_CTL;
		end else if (soft_rst_r) begin
			resetctl_r <= TCR_RST_RESET_CTL;
		end else if (wr_resetctl) begin
			resetctl_r <= reg_wdata;
			resetctl_r[TCR_RC_SOFT_RST] <= 1'b0;
			resetctl_r[TCR_RC_ACK]      <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_resetctl && reg_wdata[TCR_RC_SOFT_RST];
		end
	end

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wr_resetctl && reg_wdata[TCR_RC_ACK];
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_select && reg_read;
			if (reg_select && reg_read) begin
				case (reg_addr)
					TCR_OFS_DELAY:      reg_rdata <= delay_r;
					TCR_OFS_MESSAGE:    reg_rdata <= message_r;
					TCR_OFS_ERR_INJECT: reg_rdata <= errinj_r;
					TCR_OFS_RESET_CTL: begin
						reg_rdata <= resetctl_r;
						reg_rdata[TCR_RC_SOFT_RST] <= soft_rst_r;
						reg_rdata[TCR_RC_ACK]      <= ack_r;
					end
					default:            reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// Transmit delay
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_delay_load <= 1'b0;
		end else begin
			tx_delay_load <= wr_delay;
		end
	end

	assign tx_delay_setting = delay_r;

	tcr_frame_timer #(
		.FRAME_CYCLES (FRAME_CYCLES)
	) u_frame_timer (
		.clock       (clock),
		.rst_n       (rst_n_r),
		.load        (tx_delay_load),
		.delay       (delay_r),
		.frame_start (tx_frame_start)
	);

	// ==========================================================
	// Message and all-zeros channel path
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_channel_out       <= 8'h00;
			tx_channel_out_valid <= 1'b0;
		end else begin
			tx_channel_out_valid <= tx_channel_valid;
			if (errinj_r[TCR_EI_ZEROS]) begin
				tx_channel_out <= 8'h00;
			end else if (tx_channel_msg_sel) begin
				tx_channel_out <= message_r;
			end else begin
				tx_channel_out <= tx_channel_data;
			end
		end
	end

	assign all_zeros_inject = errinj_r[TCR_EI_ZEROS];

	// ==========================================================
	// Error insertion pulses
	tcr_edge_pulse #(
		.W (8)
	) u_edge (
		.clock    (clock),
		.rst_n    (rst_n_r),
		.write_en (wr_errinj && !soft_rst_r),
		.old_bits (errinj_r),
		.new_bits (errinj_nxt),
		.pulse    (pulses)
	);

	assign bipolar_violation_inject      = pulses[TCR_EI_BPV];
	assign crc6_fault_inject             = pulses[TCR_EI_CRC6] && esf_mode;
	assign terminal_framing_fault_inject = pulses[TCR_EI_TFRAME];
	assign signalling_framing_fault_inject =
		pulses[TCR_EI_SFRAME] && d4_mode;
	assign payload_fault_inject          = pulses[TCR_EI_PAYLOAD];

	// ==========================================================
	// Loss indicator
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			loss_indicator_pin <= 1'b0;
		end else if (errinj_r[TCR_EI_LOSS_SEL]) begin
			loss_indicator_pin <= line_loss_status;
		end else begin
			loss_indicator_pin <= line_loss_status || frame_loss_status;
		end
	end

	// ==========================================================
	// Interrupt pin and counter control
	assign interrupt_ignore       = resetctl_r[TCR_RC_SUSPEND];
	assign interrupt_status_clear = ack_r || soft_rst_r;
	// Open-drain request: driven low only while pending, released while
	// suspended or in the acknowledge cycle.
	assign irq_n_out = 1'b0;
	assign irq_n_oe  = irq_pending && !resetctl_r[TCR_RC_SUSPEND] &&
		!ack_r;
	assign counter_clear = resetctl_r[TCR_RC_CNT_CLR] || soft_rst_r;
	// Held low through the soft reset cycle as well, so that no count
	// can slip in while the counters are being cleared.
	assign counter_update_enable = !counter_clear &&
		(!resetctl_r[TCR_RC_SAMPLE] || one_second_tick);
	assign soft_reset_pulse = soft_rst_r;
	assign ext_osc_select   = resetctl_r[TCR_RC_EXT_OSC];
endmodule
`default_nettype wire

// ===== common/tcr_pkg.sv
// Constants for the transmit control, error insertion and reset register bank.
// What this block does
// - Each write of the delay register applies the transmit slip delay once.
// - Delay shifts the internal line frame boundary, always under one frame.
// - Message byte replaces data in every channel selected for message.
// - Rising write of insertion bit 7 makes one bipolar violation pulse.
// - Rising write of bit 6 corrupts one CRC-6 value in ESF mode.
// - Rising write of bit 5 makes one terminal or ESF framing error.
// - Rising write of bit 4 makes one signalling framing error, D4 only.
// - While bit 3 is set the line sends all zeros, no pulses.
// - Rising write of bit 2 flips one transmitted payload bit.
// - Bit 0 set: loss pin follows signal loss; clear: signal or frame loss.
// - Reset bit 7 returns every control register to its default and then clears itself.
// - While reset bit 6 is set, interrupt pin floats and interrupts ignored.
// - Writing reset bit 5 clears interrupt status, releases pin, self-clears.
// - While reset bit 4 is set, error counters clear and stay zero.
// - With reset bit 3 set, error counters update only on one-second ticks.
package tcr_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] TCR_OFS_RESERVED   = 8'h16;
	localparam logic [7:0] TCR_OFS_DELAY      = 8'h17;
	localparam logic [7:0] TCR_OFS_MESSAGE    = 8'h18;
	localparam logic [7:0] TCR_OFS_ERR_INJECT = 8'h19;
	localparam logic [7:0] TCR_OFS_RESET_CTL  = 8'h1A;
	// ==========================================================
	// Error insertion word fields
	localparam int TCR_EI_BPV      = 7;
	localparam int TCR_EI_CRC6     = 6;
	localparam int TCR_EI_TFRAME   = 5;
	localparam int TCR_EI_SFRAME   = 4;
	localparam int TCR_EI_ZEROS    = 3;
	localparam int TCR_EI_PAYLOAD  = 2;
	localparam int TCR_EI_LOSS_SEL = 0;
	localparam logic [7:0] TCR_EI_WMASK = 8'hFD;
	// ==========================================================
	// Reset control word fields
	localparam int TCR_RC_SOFT_RST = 7;
	localparam int TCR_RC_SUSPEND  = 6;
	localparam int TCR_RC_ACK      = 5;
	localparam int TCR_RC_CNT_CLR  = 4;
	localparam int TCR_RC_SAMPLE   = 3;
	localparam int TCR_RC_EXT_OSC  = 2;
	// ==========================================================
	// Reset values
	localparam logic [7:0] TCR_RST_DELAY     = 8'h00;
	localparam logic [7:0] TCR_RST_MESSAGE   = 8'h00;
	localparam logic [7:0] TCR_RST_ERRINJ    = 8'h00;
	localparam logic [7:0] TCR_RST_RESET_CTL = 8'h00;
	// ==========================================================
	// Timing
	localparam int TCR_CLOCK_PERIOD_NS = 20;
	localparam int TCR_FRAME_TIME_NS   = 125000;
	localparam int TCR_FRAME_CYCLES    = TCR_FRAME_TIME_NS / TCR_CLOCK_PERIOD_NS;
	localparam int TCR_DELAY_STEP_NS   = 488;
	localparam int TCR_DELAY_STEP_CYCLES =
		(TCR_DELAY_STEP_NS / TCR_CLOCK_PERIOD_NS) < 1 ? 1 :
		(TCR_DELAY_STEP_NS / TCR_CLOCK_PERIOD_NS);
	localparam int TCR_FRAME_CNT_W = 13;
endpackage

// ===== rtl/tcr_edge_pulse.sv
// Rising-change detector that turns written bits into one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module tcr_edge_pulse
	import tcr_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         write_en,
	input  wire logic [W-1:0] old_bits,
	input  wire logic [W-1:0] new_bits,
	output logic     [W-1:0] pulse
);
	// A write that leaves a bit high, or drops it, gives no pulse.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pulse <= '0;
		end else if (write_en) begin
			pulse <= new_bits & ~old_bits;
		end else begin
			pulse <= '0;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/tcr_frame_timer.sv
// Transmit line frame timer whose boundary can be moved by a delay load.
`timescale 1ns/1ps
`default_nettype none
module tcr_frame_timer
	import tcr_pkg::*;
#(
	parameter int FRAME_CYCLES = TCR_FRAME_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] delay,
	output logic            frame_start
);
	localparam logic [TCR_FRAME_CNT_W-1:0] LAST =
		TCR_FRAME_CNT_W'(FRAME_CYCLES - 1);
	localparam logic [TCR_FRAME_CNT_W-1:0] STEP =
		TCR_FRAME_CNT_W'(TCR_DELAY_STEP_CYCLES);

	logic [TCR_FRAME_CNT_W-1:0] count_r;
	logic [TCR_FRAME_CNT_W-1:0] offset;

	// The product is clamped below one frame so a large setting wraps no frame.
	always_comb begin
		offset = TCR_FRAME_CNT_W'(delay * STEP);
		if (offset >= LAST) begin
			offset = LAST - TCR_FRAME_CNT_W'(1);
		end
	end

	// ==========================================================
	// Boundary counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (load) begin
			count_r <= LAST - offset;
		end else if (count_r == LAST) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + TCR_FRAME_CNT_W'(1);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_start <= 1'b0;
		end else begin
			frame_start <= (count_r == LAST) && !load;
		end
	end
endmodule
`default_nettype wire

// ===== bench/tcr_top_props.sv
// Port-level assertions for the transmit control register bank.
`timescale 1ns/1ps
`default_nettype none
module tcr_top_props
	import tcr_pkg::*;
#(
	parameter int FRAME_CYCLES = TCR_FRAME_CYCLES
) (
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic       reg_select,
	input wire logic       reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       esf_mode,
	input wire logic [7:0] tx_delay_setting,
	input wire logic       tx_delay_load,
	input wire logic       tx_frame_start,
	input wire logic       bipolar_violation_inject,
	input wire logic       crc6_fault_inject,
	input wire logic       all_zeros_inject,
	input wire logic       line_loss_status,
	input wire logic       frame_loss_status,
	input wire logic       loss_indicator_pin,
	input wire logic       irq_n_oe,
	input wire logic       interrupt_status_clear,
	input wire logic       counter_clear,
	input wire logic       one_second_tick,
	input wire logic       counter_update_enable,
	input wire logic       soft_reset_pulse
);
	// ==========================================================
	// Shadow copies of the written control words
	logic        ew;
	logic [7:0]  ei_sh;
	logic [7:0]  rc_sh;
	logic [7:0]  ei_up;
	logic [15:0] gap;
	assign ew = reg_select && reg_write;
	assign ei_up = (ew && reg_addr == TCR_OFS_ERR_INJECT) ?
		(reg_wdata & ~ei_sh) : 8'h00;
	// A write in the soft reset cycle is overridden, so clearing wins.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ei_sh <= 8'h00;
			rc_sh <= 8'h00;
		end else if (soft_reset_pulse) begin
			ei_sh <= 8'h00;
			rc_sh <= 8'h00;
		end else if (ew && reg_addr == TCR_OFS_ERR_INJECT) begin
			ei_sh <= reg_wdata;
		end else if (ew && reg_addr == TCR_OFS_RESET_CTL) begin
			rc_sh <= reg_wdata;
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gap <= 16'h0000;
		// A delay load may stretch the frame that it lands in, so the
		// bound restarts at the load.
		end else if (tx_frame_start || tx_delay_load) begin
			gap <= 16'h0000;
		end else begin
			gap <= gap + 16'h0001;
		end
	end
	// ==========================================================
	// Assertions
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_bpv_rise: assert property (ei_up[7] |=> bipolar_violation_inject)
		else $error("bipolar pulse missing");
	a_bpv_quiet: assert property (!ei_up[7] |=> !bipolar_violation_inject)
		else $error("bipolar pulse without rising write");
	a_crc_gate: assert property (ei_up[6] |=>
		crc6_fault_inject == $past(esf_mode)) else $error("crc pulse wrong");
	a_zeros_level: assert property (all_zeros_inject == ei_sh[3])
		else $error("all zeros level wrong");
	a_loss_pick: assert property (1'b1 |=> loss_indicator_pin ==
		($past(line_loss_status) || (!$past(ei_sh[0]) &&
		$past(frame_loss_status)))) else $error("loss pin wrong");
	a_ack_release: assert property (ew && reg_addr == TCR_OFS_RESET_CTL &&
		reg_wdata[5] |=> interrupt_status_clear && !irq_n_oe)
		else $error("acknowledge not seen");
	a_soft_clear: assert property (ew && reg_addr == TCR_OFS_RESET_CTL &&
		reg_wdata[7] |=> soft_reset_pulse && counter_clear ##1 !counter_clear)
		else $error("soft reset sequence wrong");
	a_sample_gate: assert property (counter_update_enable ==
		(!counter_clear && (!rc_sh[3] || one_second_tick)))
		else $error("counter update enable wrong");
	a_delay_once: assert property (ew && reg_addr == TCR_OFS_DELAY |=>
		tx_delay_load && tx_delay_setting == $past(reg_wdata)
		##1 !tx_delay_load) else $error("delay load wrong");
	a_frame_short: assert property (gap < FRAME_CYCLES + 4)
		else $error("frame boundary too late");
	c_bpv: cover property (bipolar_violation_inject);
	c_soft: cover property (soft_reset_pulse);
	c_frame: cover property (tx_delay_load ##[1:200] tx_frame_start);
endmodule
bind tcr_top tcr_top_props #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (.*);
`default_nettype wire

// ===== bench/tcr_host.sv
// Host processor model that runs register cycles on the bank.
`timescale 1ns/1ps
`default_nettype none
module tcr_host (
	input  wire logic       clock,
	input  wire logic       reg_rvalid,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_select,
	output logic            reg_write,
	output logic            reg_read,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial begin
		{reg_select, reg_write, reg_read} = 3'b000;
		{reg_addr, reg_wdata} = 16'h0000;
	end
	// Released address and data lines show the inverse of their last value, not a hold; select, write and read drop to zero.
	task automatic access(input logic w, input logic [7:0] a, d);
		@(posedge clock);
		{reg_select, reg_write, reg_read} <= {1'b1, w, !w};
		{reg_addr, reg_wdata} <= {a, d};
		@(posedge clock);
		{reg_select, reg_write, reg_read} <= 3'b000;
		{reg_addr, reg_wdata} <= {~a, ~d};
	endtask
	task automatic wr(input logic [7:0] a, d);
		access(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		access(1'b0, a, 8'h00);
		@(posedge clock);
		d = reg_rvalid ? reg_rdata : 8'hXX;
	endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking testbench for the transmit control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tcr_pkg::*;
;
	localparam int FC = 64;
	logic clock, reset_n, reg_select, reg_write, reg_read, reg_rvalid;
	logic d4_mode, esf_mode, tx_channel_valid, tx_channel_msg_sel;
	logic tx_channel_out_valid, tx_delay_load, tx_frame_start;
	logic bipolar_violation_inject, crc6_fault_inject, payload_fault_inject;
	logic terminal_framing_fault_inject, signalling_framing_fault_inject;
	logic all_zeros_inject, line_loss_status, frame_loss_status;
	logic loss_indicator_pin, irq_pending, irq_n_out, irq_n_oe;
	logic interrupt_ignore, interrupt_status_clear, counter_clear;
	logic one_second_tick, counter_update_enable, soft_reset_pulse;
	logic ext_osc_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_channel_data;
	logic [7:0] tx_channel_out, tx_delay_setting, rd_v;
	logic [4:0] pv;
	int         fail_count, total_checks, n;
	localparam logic [23:0] ROWS [9] = '{24'h170F0F, 24'h18A5A5,
		24'h190909, 24'h19FFFD, 24'h1A5C5C, 24'h1A0000, 24'h163300,
		24'h1FFF00, 24'h190000};
	assign pv = {bipolar_violation_inject, crc6_fault_inject,
		terminal_framing_fault_inject, signalling_framing_fault_inject,
		payload_fault_inject};
	tcr_top #(.FRAME_CYCLES(FC)) dut (.*);
	tcr_host host (.*);
	initial clock = 1'b0;
	always #10 clock = ~clock;
	// ==========================================================
	// Checking and closing
	task automatic chk(input string nm, input logic [7:0] e, s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic pulse(input logic [7:0] d, e);
		host.wr(TCR_OFS_ERR_INJECT, d);
		@(posedge clock);
		chk("pulses", e, {3'b000, pv});
	endtask
	task automatic chan(input logic [7:0] d, input logic s, input logic [7:0] e);
		@(posedge clock);
		{tx_channel_valid, tx_channel_data, tx_channel_msg_sel} <= {1'b1, d, s};
		@(posedge clock);
		{tx_channel_valid, tx_channel_data} <= {1'b0, ~d};
		@(posedge clock);
		chk("channel valid", 8'h01, tx_channel_out_valid);
		chk("channel byte", e, tx_channel_out);
	endtask
	task automatic wait_frame();
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (tx_frame_start !== 1'b1 && n < 2 * FC);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		#400000;
		fail_count++;
		complete_run();
	end
	initial begin
		{reset_n, tx_channel_valid, tx_channel_data, tx_channel_msg_sel} = '0;
		{line_loss_status, frame_loss_status, irq_pending} = 3'b000;
		{d4_mode, esf_mode, one_second_tick} = 3'b110;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		for (int a = 8'h16; a <= 8'h1A; a++) begin
			host.rd(8'(a), rd_v);
			chk("reset value", 8'h00, rd_v);
		end
		for (int i = 0; i < 9; i++) begin
			host.wr(ROWS[i][23:16], ROWS[i][15:8]);
			host.rd(ROWS[i][23:16], rd_v);
			chk("readback", ROWS[i][7:0], rd_v);
		end
		pulse(8'hF4, 8'h1F);
		pulse(8'hF4, 8'h00);
		pulse(8'h00, 8'h00);
		esf_mode <= 1'b0;
		pulse(8'h50, 8'h02);
		pulse(8'h00, 8'h00);
		{d4_mode, esf_mode} <= 2'b01;
		pulse(8'h50, 8'h08);
		host.wr(TCR_OFS_MESSAGE, 8'h3C);
		chan(8'h81, 1'b0, 8'h81);
		chan(8'h81, 1'b1, 8'h3C);
		pulse(8'h08, 8'h00);
		chan(8'h81, 1'b1, 8'h00);
		host.wr(TCR_OFS_ERR_INJECT, 8'h01);
		frame_loss_status <= 1'b1;
		repeat (2) @(posedge clock);
		chk("loss pin", 8'h00, loss_indicator_pin);
		line_loss_status <= 1'b1;
		repeat (2) @(posedge clock);
		chk("loss pin", 8'h01, loss_indicator_pin);
		line_loss_status <= 1'b0;
		host.wr(TCR_OFS_ERR_INJECT, 8'h00);
		repeat (2) @(posedge clock);
		chk("loss pin", 8'h01, loss_indicator_pin);
		{frame_loss_status, irq_pending} <= 2'b01;
		@(posedge clock);
		chk("irq drive", 8'h01, irq_n_oe);
		chk("irq level", 8'h00, irq_n_out);
		host.wr(TCR_OFS_RESET_CTL, 8'h20);
		@(posedge clock);
		chk("status clear", 8'h01, interrupt_status_clear);
		chk("irq release", 8'h00, irq_n_oe);
		host.rd(TCR_OFS_RESET_CTL, rd_v);
		chk("ack self clear", 8'h00, rd_v);
		host.wr(TCR_OFS_RESET_CTL, 8'h48);
		@(posedge clock);
		chk("irq suspend", 8'h00, irq_n_oe);
		chk("irq ignore", 8'h01, 8'(interrupt_ignore));
		chk("counter hold", 8'h00, counter_update_enable);
		one_second_tick <= 1'b1;
		@(posedge clock);
		chk("counter tick", 8'h01, counter_update_enable);
		one_second_tick <= 1'b0;
		host.wr(TCR_OFS_RESET_CTL, 8'h14);
		@(posedge clock);
		chk("counter clear", 8'h01, counter_clear);
		chk("osc select", 8'h01, 8'(ext_osc_select));
		host.wr(TCR_OFS_MESSAGE, 8'h77);
		host.wr(TCR_OFS_RESET_CTL, 8'h80);
		@(posedge clock);
		chk("soft reset", 8'h01, soft_reset_pulse);
		host.rd(TCR_OFS_MESSAGE, rd_v);
		chk("soft reset value", 8'h00, rd_v);
		host.rd(TCR_OFS_RESET_CTL, rd_v);
		chk("soft reset self clear", 8'h00, rd_v);
		chk("osc after reset", 8'h00, 8'(ext_osc_select));
		host.wr(TCR_OFS_DELAY, 8'h0F);
		@(posedge clock);
		chk("delay load", 8'h01, tx_delay_load);
		chk("delay value", 8'h0F, tx_delay_setting);
		wait_frame();
		chk("frame shift", 8'h01, n <= FC + 2);
		wait_frame();
		chk("frame length", 8'(FC), 8'(n));
		complete_run();
	end
endmodule
`default_nettype wire
